// ===== rtl/amscr_regs.sv
`include "amscr_cfg.svh"
// ----------------------------------------
// misc analog and serializer config bank
// ----------------------------------------
module amscr_regs
  import amscr_pkg::*;
#(
  parameter int LANES = `AMSCR_LANES
) (
  input  wire logic               sys_clk,        // 50 mhz clock
  input  wire logic               resetn,         // async reset, low
  input  wire logic               clk_en,         // freezes state when low
  input  wire logic [7:0]         reg_addr,       // register byte address
  input  wire logic [7:0]         reg_wdata,      // write data
  input  wire logic               reg_wr,         // write strobe
  input  wire logic               reg_rd,         // read strobe
  output logic      [7:0]         reg_rdata,      // read data, next cycle
  input  wire logic [23:0]        edge_pos_raw,   // measured edge position
  output logic      [15:0]        fullscale_a,    // input a trim
  output logic      [15:0]        fullscale_b,    // input b trim
  output logic                    ref_bypass,     // supply as reference
  output logic                    timestamp_receiver_enable,  // timestamp receiver on
  output logic                    timestamp_input_pecl_en,  // timestamp lvpecl mode
  output logic      [3:0]         delay_select,   // sysref delay select
  output logic                    delay_auto,     // automatic calibration
  output logic                    magnify,        // edge status magnify
  output logic      [LANES*4-1:0] lane_pe         // per-lane pre-emphasis
);
  amscr_req_t  req;
  amscr_ctrl_t ctrl;
  logic [15:0] fs_a;
  logic [15:0] fs_b;
  logic [7:0]  ref_byp;
  logic [7:0]  timestamp_input;
  logic [7:0]  preemph;
  logic [7:0]  clk_ctrl;
  logic [23:0] edge_sync;
  logic [23:0] edge_pos;
  logic [7:0]  next_rdata;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ----------------------------------------
  // status capture
  // ----------------------------------------
  amscr_sync #(
    .W (24)
  ) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .d       (edge_pos_raw),
    .q       (edge_sync)
  );

  // magnify scales the status so software sees finer steps
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      edge_pos <= 24'h000000;
    end else if (clk_en) begin
      if (clk_ctrl[`AMSCR_MAGNIFY_BIT]) begin
        edge_pos <= {edge_sync[11:0], 12'h000};
      end else begin
        edge_pos <= edge_sync;
      end
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  // full-scale trims, msb at lower address; low codes accepted as is
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fs_a <= `AMSCR_FS_RESET;
      fs_b <= `AMSCR_FS_RESET;
    end else if (clk_en && req.wr) begin
      case (req.addr)
        `AMSCR_FS_A_ADDR0: fs_a[15:8] <= req.wdata;
        `AMSCR_FS_A_ADDR1: fs_a[7:0]  <= req.wdata;
        `AMSCR_FS_B_ADDR0: fs_b[15:8] <= req.wdata;
        `AMSCR_FS_B_ADDR1: fs_b[7:0]  <= req.wdata;
        default: ;
      endcase
    end
  end

  // byte registers keep reserved bits but never use them
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ref_byp  <= `AMSCR_BYTE_RESET;
      timestamp_input    <= `AMSCR_BYTE_RESET;
      preemph  <= `AMSCR_BYTE_RESET;
      clk_ctrl <= `AMSCR_BYTE_RESET;
    end else if (clk_en && req.wr) begin
      case (req.addr)
        `AMSCR_REF_BYP_ADDR:  ref_byp  <= req.wdata;
        `AMSCR_TIMESTAMP_INPUT_ADDR:    timestamp_input    <= req.wdata;
        `AMSCR_PREEMPH_ADDR:  preemph  <= req.wdata;
        `AMSCR_CLK_CTRL_ADDR: clk_ctrl <= req.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // control outputs, registered
  // ----------------------------------------
  always_comb begin
    ctrl.fullscale_a   = fs_a;
    ctrl.fullscale_b   = fs_b;
    ctrl.ref_bypass    = ref_byp[`AMSCR_REF_BYP_BIT];
    ctrl.timestamp_receiver_enable = timestamp_input[`AMSCR_TIMESTAMP_INPUT_RECV_BIT];
    ctrl.timestamp_input_pecl_en = timestamp_input[`AMSCR_TIMESTAMP_INPUT_PECL_BIT];
    ctrl.preemph       = preemph[3:0];
    ctrl.delay_select  = clk_ctrl[3:0];
    ctrl.delay_auto    = (clk_ctrl[3:0] == `AMSCR_DLY_AUTO);
    ctrl.magnify       = clk_ctrl[`AMSCR_MAGNIFY_BIT];
  end

  // one cycle of latency buys flop-driven analog controls
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fullscale_a   <= `AMSCR_FS_RESET;
      fullscale_b   <= `AMSCR_FS_RESET;
      ref_bypass    <= 1'b0;
      timestamp_receiver_enable <= 1'b0;
      timestamp_input_pecl_en <= 1'b0;
      delay_select  <= 4'h0;
      delay_auto    <= 1'b1;
      magnify       <= 1'b0;
    end else if (clk_en) begin
      fullscale_a   <= ctrl.fullscale_a;
      fullscale_b   <= ctrl.fullscale_b;
      ref_bypass    <= ctrl.ref_bypass;
      timestamp_receiver_enable <= ctrl.timestamp_receiver_enable;
      timestamp_input_pecl_en <= ctrl.timestamp_input_pecl_en;
      delay_select  <= ctrl.delay_select;
      delay_auto    <= ctrl.delay_auto;
      magnify       <= ctrl.magnify;
    end
  end

  amscr_lane_fan #(
    .LANES (LANES)
  ) u_fan (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .setting (ctrl.preemph),
    .lane_pe (lane_pe)
  );

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // unmapped addresses read zero
  always_comb begin
    case (req.addr)
      `AMSCR_CLK_CTRL_ADDR:  next_rdata = clk_ctrl;
      `AMSCR_EDGE_POS_ADDR0: next_rdata = edge_pos[23:16];
      `AMSCR_EDGE_POS_ADDR1: next_rdata = edge_pos[15:8];
      `AMSCR_EDGE_POS_ADDR2: next_rdata = edge_pos[7:0];
      `AMSCR_FS_A_ADDR0:     next_rdata = fs_a[15:8];
      `AMSCR_FS_A_ADDR1:     next_rdata = fs_a[7:0];
      `AMSCR_FS_B_ADDR0:     next_rdata = fs_b[15:8];
      `AMSCR_FS_B_ADDR1:     next_rdata = fs_b[7:0];
      `AMSCR_REF_BYP_ADDR:   next_rdata = ref_byp;
      `AMSCR_TIMESTAMP_INPUT_ADDR:     next_rdata = timestamp_input;
      `AMSCR_PREEMPH_ADDR:   next_rdata = preemph;
      default:               next_rdata = 8'h00;
    endcase
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= req.rd ? next_rdata : 8'h00;
    end
  end
endmodule

// ===== rtl/amscr_cfg.svh
`ifndef AMSCR_CFG_SVH
`define AMSCR_CFG_SVH
// Summary of operation
// - read-only 24-bit sysref edge position status
// - input A 16-bit fullscale trim, reset a000
// - input B 16-bit fullscale trim, reset a000
// - bypass bit 0 selects analog supply reference
// - timestamp bit 0 enables input receiver
// - timestamp bit 1 selects low-volt pecl mode
// - 4-bit pre-emphasis common to all lanes
// - delay select zero means automatic calibration
// - magnify bit changes edge position resolution

// ----------------------------------------
// address map, byte-wide registers
// ----------------------------------------
`define AMSCR_ADDR_W          8
`define AMSCR_CLK_CTRL_ADDR   8'h29
`define AMSCR_EDGE_POS_ADDR0  8'h2c
`define AMSCR_EDGE_POS_ADDR1  8'h2d
`define AMSCR_EDGE_POS_ADDR2  8'h2e
`define AMSCR_FS_A_ADDR0      8'h30
`define AMSCR_FS_A_ADDR1      8'h31
`define AMSCR_FS_B_ADDR0      8'h32
`define AMSCR_FS_B_ADDR1      8'h33
`define AMSCR_REF_BYP_ADDR    8'h38
`define AMSCR_TIMESTAMP_INPUT_ADDR      8'h3b
`define AMSCR_PREEMPH_ADDR    8'h48

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define AMSCR_FS_RESET        16'ha000
`define AMSCR_BYTE_RESET      8'h00
`define AMSCR_REF_BYP_BIT     0
`define AMSCR_TIMESTAMP_INPUT_RECV_BIT  0
`define AMSCR_TIMESTAMP_INPUT_PECL_BIT  1
`define AMSCR_DLY_SEL_LSB     0
`define AMSCR_MAGNIFY_BIT     4
`define AMSCR_PREEMPH_LSB     0
`define AMSCR_DLY_AUTO        4'h0
`define AMSCR_LANES           16
`endif

// ===== rtl/amscr_pkg.sv
package amscr_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } amscr_req_t;

  typedef struct packed {
    logic [15:0] fullscale_a;
    logic [15:0] fullscale_b;
    logic        ref_bypass;
    logic        timestamp_receiver_enable;
    logic        timestamp_input_pecl_en;
    logic [3:0]  preemph;
    logic [3:0]  delay_select;
    logic        delay_auto;
    logic        magnify;
  } amscr_ctrl_t;
endpackage

// ===== rtl/amscr_sync.sv
`include "amscr_cfg.svh"
// two-stage synchroniser for the edge position status bus
module amscr_sync
  import amscr_pkg::*;
#(
  parameter int W = 24
) (
  input  wire logic         sys_clk, // clock
  input  wire logic         resetn,  // async reset
  input  wire logic         clk_en,  // clock enable
  input  wire logic [W-1:0] d,       // async input
  output logic      [W-1:0] q        // synchronised
);
  logic [W-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      q    <= '0;
    end else if (clk_en) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ===== rtl/amscr_lane_fan.sv
`include "amscr_cfg.svh"
// fans the single pre-emphasis setting to every serial lane
module amscr_lane_fan
  import amscr_pkg::*;
#(
  parameter int LANES = `AMSCR_LANES
) (
  input  wire logic              sys_clk,   // clock
  input  wire logic              resetn,    // async reset
  input  wire logic              clk_en,    // clock enable
  input  wire logic [3:0]        setting,   // common setting
  output logic      [LANES*4-1:0] lane_pe   // per-lane copies
);
  genvar g;
  // one register per lane keeps fanout local to each serializer
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          lane_pe[g*4 +: 4] <= 4'h0;
        end else if (clk_en) begin
          lane_pe[g*4 +: 4] <= setting;
        end
      end
    end
  endgenerate
endmodule

// ===== verif/amscr_regs_asserts.sv
module amscr_regs_asserts
  import amscr_pkg::*;
#(
  parameter int LANES = 16
) (
  input wire logic               sys_clk,      // clock
  input wire logic               resetn,       // reset
  input wire logic               clk_en,       // enable
  input wire logic [7:0]         reg_addr,     // address
  input wire logic [7:0]         reg_wdata,    // wdata
  input wire logic               reg_wr,       // write
  input wire logic               reg_rd,       // read
  input wire logic [7:0]         reg_rdata,    // rdata
  input wire logic [15:0]        fullscale_a,  // trim a
  input wire logic [15:0]        fullscale_b,  // trim b
  input wire logic               ref_bypass,   // bypass
  input wire logic [3:0]         delay_select, // delay
  input wire logic               delay_auto,   // auto
  input wire logic [LANES*4-1:0] lane_pe       // lanes
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // register port and control outputs
  // ----------------------------------------
  chk_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_unmapped_rd: assert property (clk_en && reg_rd && !(reg_addr inside {8'h29, 8'h2c, 8'h2d, 8'h2e,
    8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h3b, 8'h48}) |=> reg_rdata == 8'h00) else $error("unmapped read");
  chk_fsa_write: assert property (clk_en && reg_wr && reg_addr == 8'h30 ##1 clk_en
    |=> fullscale_a[15:8] == $past(reg_wdata, 2)) else $error("trim a msb");
  chk_fsa_hold: assert property (!$past(reg_wr, 2) && $past(clk_en, 2) |-> $stable(fullscale_a))
    else $error("trim a moved");
  chk_fsb_write: assert property (clk_en && reg_wr && reg_addr == 8'h33 ##1 clk_en
    |=> fullscale_b[7:0] == $past(reg_wdata, 2)) else $error("trim b lsb");
  chk_bypass_write: assert property (clk_en && reg_wr && reg_addr == 8'h38 ##1 clk_en
    |=> ref_bypass == $past(reg_wdata[0], 2)) else $error("bypass");
  chk_delay_auto: assert property (delay_auto == (delay_select == 4'h0))
    else $error("auto select");
  chk_lane_copy: assert property (lane_pe == {LANES{lane_pe[3:0]}})
    else $error("lanes differ");
  chk_pe_write: assert property (clk_en && reg_wr && reg_addr == 8'h48 ##1 clk_en
    |=> lane_pe[3:0] == $past(reg_wdata[3:0], 2)) else $error("pre-emphasis");
endmodule

bind amscr_regs amscr_regs_asserts #(.LANES(LANES)) u_chk (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .fullscale_a(fullscale_a), .fullscale_b(fullscale_b), .ref_bypass(ref_bypass),
  .delay_select(delay_select), .delay_auto(delay_auto), .lane_pe(lane_pe));

// ===== verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_pend = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [23:0] raw = 24'h000000;
  logic [15:0] fs_a, fs_b, st = 16'h0013;
  logic ref_bypass, timestamp_receiver_enable, timestamp_input_pecl_en, delay_auto, magnify;
  logic [3:0] delay_select;
  logic [63:0] lane_pe;
  logic [7:0] q [$];
  int n_errors = 0, check_count = 0;
  localparam logic [7:0] AD [9] = '{8'h29, 8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h3b, 8'h48, 8'h34};
  localparam logic [7:0] RV [9] = '{8'h00, 8'ha0, 8'h00, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #10 sys_clk = ~sys_clk;
  amscr_regs #(.LANES(16)) DUT (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .edge_pos_raw(raw),
    .fullscale_a(fs_a), .fullscale_b(fs_b), .ref_bypass(ref_bypass), .timestamp_receiver_enable(timestamp_receiver_enable),
    .timestamp_input_pecl_en(timestamp_input_pecl_en), .delay_select(delay_select), .delay_auto(delay_auto),
    .magnify(magnify), .lane_pe(lane_pe));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // every strobe is set on each call, so no signal is assigned twice in a step
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  // status passes sync and scaling flops before it can be read
  task automatic pos_rd(input logic [23:0] e);
    repeat (4) bus(1'b0, 1'b0, 8'h00, 8'h00);
    for (int i = 0; i < 3; i++) rd(8'(8'h2c + i), e[23-8*i -: 8]);
  endtask
  // strobes dropped first so a read never stands twice;
  // sampled at the falling edge, clear of the update edge
  task automatic outs(input logic [7:0] v [9]);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge sys_clk);
    chk("fullscale_a", {v[1], v[2]}, fs_a);
    chk("fullscale_b", {v[3], v[4]}, fs_b);
    chk("ref_bypass", v[5][0], ref_bypass);
    chk("timestamp_receiver_enable", v[6][0], timestamp_receiver_enable);
    chk("timestamp_input_pecl_en", v[6][1], timestamp_input_pecl_en);
    chk("delay_select", v[0][3:0], delay_select);
    chk("delay_auto", v[0][3:0] == 4'h0, delay_auto);
    chk("magnify", v[0][4], magnify);
    chk("lane_pe", {16{v[7][3:0]}}, lane_pe);
    @(posedge sys_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // read data checker, oldest note first
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rd_pend) chk("reg_rdata", q.pop_front(), reg_rdata);
    rd_pend <= reg_rd && clk_en;
  end
  initial begin
    int i;
    logic [7:0] w;
    logic [7:0] v [9];
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    outs(RV);
    for (i = 0; i < 9; i++) rd(AD[i], RV[i]);
    // status ignores writes; magnify moves the low bits up
    st = lfsr(st);
    raw <= {st, st[15:8] ^ 8'h5a};
    for (i = 0; i < 3; i++) bus(1'b1, 1'b0, 8'(8'h2c + i), 8'hff);
    pos_rd(raw);
    bus(1'b1, 1'b0, 8'h29, {4'h1, raw[23:20]});
    pos_rd({raw[11:0], 12'h000});
    // write then read back to back, zero delay select in round one
    for (int r = 0; r < 3; r++) begin
      for (i = 0; i < 9; i++) begin
        st = lfsr(st);
        w = (r == 1 && i == 0) ? (st[7:0] & 8'hf0) : st[7:0];
        if (i == 1 || i == 3) w = w | 8'h20;
        v[i] = (i == 8) ? 8'h00 : w;
        bus(1'b1, 1'b0, AD[i], w);
        rd(AD[i], v[i]);
      end
      outs(v);
    end
    // a write while frozen is not taken
    clk_en <= 1'b0;
    bus(1'b1, 1'b0, 8'h38, ~v[5]);
    clk_en <= 1'b1;
    rd(8'h38, v[5]);
    repeat (2) bus(1'b0, 1'b0, 8'h00, 8'h00);
    resetn <= 1'b0;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    resetn <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    outs(RV);
    for (i = 0; i < 20 && q.size() > 0; i++) @(posedge sys_clk);
    if (q.size() > 0) begin
      n_errors++;
      $display("[FAIL] read queue expected 0 seen %0d", q.size());
    end
    tally_and_finish();
  end
endmodule
